// File: inc/pst_pkg.sv
// package for the public spanning tree frame handler
package pst_pkg;
  // multicast destination and snap header for public tree frames, group address and llc for standard ones
  localparam logic [47:0] PST_MCAST     = 48'h01e02f000003;
  localparam logic [47:0] PST_STD_GROUP = 48'h0180c2000000;
  localparam logic [63:0] PST_SNAP      = 64'haaaa0300e02f7374;
  localparam logic [23:0] PST_STD_LLC   = 24'h424203;
  // bpdu type octets
  localparam logic [7:0]  PST_TYPE_CFG  = 8'h00;
  localparam logic [7:0]  PST_TYPE_TCN  = 8'h80;
  // default priorities
  localparam logic [15:0] PST_PRIO_MODEM = 16'h9000;
  localparam logic [15:0] PST_PRIO_HEAD  = 16'h8000;
  // path cost numerator (cost = 1000 / mbit/s, rate in ksym/s)
  localparam logic [31:0] PST_COST_NUM  = 32'h000f4240;
  localparam logic [15:0] PST_COST_100M = 16'h000a;
  // register byte offsets
  localparam logic [7:0] PST_REG_CTRL   = 8'h00;
  localparam logic [7:0] PST_REG_PRIO   = 8'h04;
  localparam logic [7:0] PST_REG_RATE   = 8'h08;
  localparam logic [7:0] PST_REG_COST   = 8'h0c;
  localparam logic [7:0] PST_REG_NSCOST = 8'h10;
  localparam logic [7:0] PST_REG_STAT   = 8'h14;
  localparam logic [7:0] PST_REG_CNT    = 8'h18;
  localparam logic [7:0] PST_REG_TXD    = 8'h1c;
  localparam logic [7:0] PST_REG_RXD    = 8'h20;
  // control bit positions
  localparam int PST_CTL_HEAD  = 0;
  localparam int PST_CTL_QAM16 = 1;
  localparam int PST_CTL_TXGO  = 2;
  localparam int PST_CTL_FWD   = 3;
  // axi responses
  localparam logic [1:0] PST_OKAY   = 2'h0;
  localparam logic [1:0] PST_SLVERR = 2'h2;
  // frame build states of the transmit framer, gray along the path
  typedef enum logic [2:0] {
    PST_IDLE = 3'h0,
    PST_HDR  = 3'h1,
    PST_BODY = 3'h3,
    PST_DONE = 3'h2
  } pst_tx_t;
  localparam int PST_HDR_BYTES = 22;
  localparam int PST_BODY_MAX  = 64;
endpackage

// File: design/pst_fifo.sv
// small synchronous fifo with valid/ready on both sides
module pst_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  // elaboration check: pointer wrap logic needs a power of two
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("depth must be power of 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];   // storage
  logic [AW:0]      wr_q;          // write pointer with wrap bit
  logic [AW:0]      rd_q;          // read pointer with wrap bit
  wire  push = in_valid && in_ready;
  wire  pop  = out_valid && out_ready;
  // full when pointers differ only in wrap bit
  assign in_ready  = !((wr_q[AW] != rd_q[AW]) &&
                       (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem[rd_q[AW-1:0]];
  // pointer update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
    end
  end
  // storage write, no reset needed
  always_ff @(posedge aclk) begin
    if (push) mem[wr_q[AW-1:0]] <= in_data;
  end
endmodule

// File: design/pst_handler.sv
// public spanning tree frame handler with axi4-lite registers
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
module pst_handler #(
  parameter int  FIFO_DEPTH = 16,
  parameter bit  HEAD_STRAP = 1'b0
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // receive byte stream from the mac (same clock)
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  input  wire logic        rx_last,
  input  wire logic        rx_upstream,
  output logic             rx_ready,
  // transmit byte stream toward all ports
  output logic [7:0]       tx_data,
  output logic             tx_valid,
  output logic             tx_last,
  output logic [2:0]       tx_port_mask,
  input  wire logic        tx_ready,
  // accepted public bpdu body toward the protocol engine
  output logic [7:0]       eng_data,
  output logic             eng_valid,
  output logic             eng_last,
  input  wire logic        eng_ready
);
  // elaboration check on the outgoing fifo size
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("fifo depth too small");
  end

  // ---------------- register state ----------------
  logic [31:0] ctrl_q;     // mode, modulation, transmit start, forward enable
  logic [15:0] prio_q;     // bridge priority
  logic [15:0] rate_q;     // symbol rate in ksym/s
  logic [15:0] cost_q;     // rf/cable path cost
  logic [15:0] nscost_q;   // network side port cost
  logic        cost_ovr_q; // software wrote a cost, stop auto derivation
  logic [15:0] n_pub_q;    // public bpdus accepted
  logic [15:0] n_drop_q;   // standard/tcn/other frames dropped
  logic [7:0]  txbuf [pst_pkg::PST_BODY_MAX]; // bpdu body to send
  logic [5:0]  txlen_q;    // body length in bytes
  logic        busy_tx;
  logic        reset_done_q;

  wire head = ctrl_q[pst_pkg::PST_CTL_HEAD];

  // default cost: 1e6 / (ksym * bits); bits 2 for qpsk, 4 for 16qam
  // rounded to nearest so the documented table comes out exact
  function automatic logic [15:0] pst_cost(input logic [15:0] ksym,
                                           input logic        q16);
    logic [31:0] den;
    logic [31:0] quo;
    den = {14'h0, ksym, (q16 ? 2'h0 : 2'h0)} >> (q16 ? 0 : 1);
    if (den == '0) den = 32'h1;
    quo = (pst_pkg::PST_COST_NUM + (den >> 1)) / den;
    return (quo > 32'h0000ffff) ? 16'hffff : quo[15:0];
  endfunction

  // ---------------- axi4-lite write path ----------------
  logic        aw_have_q, w_have_q;
  logic [7:0]  aw_q;
  logic [31:0] w_q;
  logic [3:0]  ws_q;
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  wire wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

  // capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_q      <= '0;
      w_q       <= '0;
      ws_q      <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_q      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_q      <= s_axi_wdata;
        ws_q     <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
      end
    end
  end

  function automatic logic [31:0] pst_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction
  wire [31:0] wmix_ctrl = pst_merge(ctrl_q, w_q, ws_q);

  wire wr_hit = (aw_q == pst_pkg::PST_REG_CTRL) ||
                (aw_q == pst_pkg::PST_REG_PRIO) ||
                (aw_q == pst_pkg::PST_REG_RATE) ||
                (aw_q == pst_pkg::PST_REG_COST) ||
                (aw_q == pst_pkg::PST_REG_NSCOST) ||
                (aw_q == pst_pkg::PST_REG_CNT) ||
                (aw_q == pst_pkg::PST_REG_TXD);

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pst_pkg::PST_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? pst_pkg::PST_OKAY : pst_pkg::PST_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // reset values: strap sampled after release picks the role
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_done_q <= 1'b0;
    end else begin
      reset_done_q <= 1'b1;
    end
  end

  // configuration registers, full range writable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q     <= 32'h0000_0008;
      prio_q     <= pst_pkg::PST_PRIO_MODEM;
      rate_q     <= 16'h00a0;
      cost_q     <= 16'h0c35;         // 160 ksym qpsk default
      nscost_q   <= pst_pkg::PST_COST_100M;
      cost_ovr_q <= 1'b0;
    end else begin
      if (!reset_done_q && HEAD_STRAP) begin
        ctrl_q[pst_pkg::PST_CTL_HEAD] <= 1'b1;
        // better than modem default
        prio_q <= pst_pkg::PST_PRIO_HEAD;
      end
      // auto cost from rate and modulation
      if (!cost_ovr_q)
        cost_q <= pst_cost(rate_q, ctrl_q[pst_pkg::PST_CTL_QAM16]);
      if (busy_tx) ctrl_q[pst_pkg::PST_CTL_TXGO] <= 1'b0;
      if (wr_go) begin
        case (aw_q)
          pst_pkg::PST_REG_CTRL:   ctrl_q <= wmix_ctrl;
          pst_pkg::PST_REG_PRIO:   prio_q <= w_q[15:0];
          pst_pkg::PST_REG_RATE: begin
            rate_q     <= w_q[15:0];
            cost_ovr_q <= 1'b0;
          end
          pst_pkg::PST_REG_COST: begin
            cost_q     <= w_q[15:0];
            cost_ovr_q <= 1'b1;
          end
          pst_pkg::PST_REG_NSCOST: nscost_q <= w_q[15:0];
          default: ;
        endcase
      end
    end
  end

  // transmit body buffer, written by software word pushes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txlen_q <= '0;
    end else if (wr_go && aw_q == pst_pkg::PST_REG_TXD) begin
      if (w_q[8]) begin
        txlen_q <= '0;                 // bit 8 clears the body
      end else if (txlen_q != 6'h3f) begin
        txlen_q <= txlen_q + 6'h01;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (wr_go && aw_q == pst_pkg::PST_REG_TXD && !w_q[8]) begin
      txbuf[txlen_q] <= w_q[7:0];
    end
  end

  // ---------------- transmit framer ----------------
  pst_pkg::pst_tx_t tx_st_q;
  logic [5:0]  tx_idx_q;
  logic [7:0]  f_data;
  logic        f_valid, f_last, f_ready;
  assign busy_tx = (tx_st_q != pst_pkg::PST_IDLE);

  // header byte: dest mcast, src zero, length, snap
  always_comb begin
    f_data = 8'h00;
    if (tx_idx_q < 6'd6)
      f_data = pst_pkg::PST_MCAST[8*(5 - tx_idx_q[2:0]) +: 8];
    else if (tx_idx_q == 6'd12)
      f_data = 8'h00;
    else if (tx_idx_q == 6'd13)
      f_data = {2'h0, txlen_q} + 8'h08;
    else if (tx_idx_q >= 6'd14)
      f_data = pst_pkg::PST_SNAP[8*(21 - tx_idx_q) +: 8];
    if (tx_st_q == pst_pkg::PST_BODY) f_data = txbuf[tx_idx_q];
  end
  // tcn bodies (type 0x80) are refused; only config is framed
  wire tx_ok = (txlen_q > 6'd3) && (txbuf[3] == pst_pkg::PST_TYPE_CFG);
  assign f_valid = (tx_st_q == pst_pkg::PST_HDR) ||
                   (tx_st_q == pst_pkg::PST_BODY);
  assign f_last  = (tx_st_q == pst_pkg::PST_BODY) &&
                   (tx_idx_q == txlen_q - 6'd1);

  // framer sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st_q  <= pst_pkg::PST_IDLE;
      tx_idx_q <= '0;
    end else begin
      case (tx_st_q)
        pst_pkg::PST_IDLE: if (ctrl_q[pst_pkg::PST_CTL_TXGO] && tx_ok) begin
          tx_st_q  <= pst_pkg::PST_HDR;
          tx_idx_q <= '0;
        end
        pst_pkg::PST_HDR: if (f_ready) begin
          if (tx_idx_q == 6'(pst_pkg::PST_HDR_BYTES - 1)) begin
            tx_st_q  <= pst_pkg::PST_BODY;
            tx_idx_q <= '0;
          end else begin
            tx_idx_q <= tx_idx_q + 6'h01;
          end
        end
        pst_pkg::PST_BODY: if (f_ready) begin
          if (f_last) tx_st_q <= pst_pkg::PST_DONE;
          else tx_idx_q <= tx_idx_q + 6'h01;
        end
        pst_pkg::PST_DONE: tx_st_q <= pst_pkg::PST_IDLE;
        default:  tx_st_q <= pst_pkg::PST_IDLE;
      endcase
    end
  end

  // outgoing fifo stalls the framer when the mac is slow
  logic [8:0] fo_data;
  pst_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_txf (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .in_data  ({f_last, f_data}),
    .in_valid (f_valid),
    .in_ready (f_ready),
    .out_data (fo_data),
    .out_valid(tx_valid),
    .out_ready(tx_ready)
  );
  assign tx_data = fo_data[7:0];
  assign tx_last = fo_data[8];
  // all links: subscriber/network, rf, second side
  assign tx_port_mask = 3'h7;

  // ---------------- receive classifier ----------------
  logic [5:0]  rx_idx_q;
  logic        rx_pub_q;   // dest and snap matched so far
  logic        rx_bad_q;   // tcn type octet seen
  logic        rx_fwd_q;   // echo toward downstream
  wire rx_take = rx_valid && rx_ready;
  wire [7:0] exp_b = (rx_idx_q < 6'd6) ?
                     pst_pkg::PST_MCAST[8*(5 - rx_idx_q[2:0]) +: 8] :
                     pst_pkg::PST_SNAP[8*(21 - rx_idx_q) +: 8];
  wire chk = (rx_idx_q < 6'd6) || (rx_idx_q >= 6'd14 &&
             rx_idx_q < 6'(pst_pkg::PST_HDR_BYTES));
  wire in_body = (rx_idx_q >= 6'(pst_pkg::PST_HDR_BYTES));
  // the type octet sits 3 bytes into the body; the three bytes before it
  // are already passed, but a tcn frame is never closed toward the engine
  wire is_tcn  = (rx_idx_q == 6'(pst_pkg::PST_HDR_BYTES + 3)) &&
                 (rx_data == pst_pkg::PST_TYPE_TCN);
  assign rx_ready = eng_ready;
  // only fully matched public frames reach the engine
  assign eng_valid = rx_valid && in_body && rx_pub_q && !rx_bad_q &&
                     !is_tcn;
  assign eng_data  = rx_data;
  assign eng_last  = rx_last;

  // byte walk and match tracking; private trees never reach the
  // engine since their frames carry the standard group
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_idx_q <= '0;
      rx_pub_q <= 1'b1;
      rx_bad_q <= 1'b0;
      rx_fwd_q <= 1'b0;
      n_pub_q  <= '0;
      n_drop_q <= '0;
    end else if (rx_take) begin
      if (rx_idx_q != 6'h3f) rx_idx_q <= rx_idx_q + 6'h01;
      if (chk && rx_data != exp_b) rx_pub_q <= 1'b0;
      if (is_tcn) rx_bad_q <= 1'b1;   // tcn has no effect
      if (rx_idx_q == 6'h00) rx_fwd_q <= rx_upstream;
      if (rx_last) begin
        rx_idx_q <= '0;
        rx_pub_q <= 1'b1;
        rx_bad_q <= 1'b0;
        if (rx_pub_q && !rx_bad_q && !is_tcn && in_body)
          n_pub_q <= n_pub_q + 16'h0001;
        else
          n_drop_q <= n_drop_q + 16'h0001;
      end
    end else if (wr_go && aw_q == pst_pkg::PST_REG_CNT) begin
      n_pub_q  <= '0;
      n_drop_q <= '0;
    end
  end
  // headend with forwarding on flags upstream bpdus for downstream echo in the status word
  wire fwd_req = head && ctrl_q[pst_pkg::PST_CTL_FWD] && rx_fwd_q;

  // ---------------- axi4-lite read path ----------------
  wire [31:0] stat = {26'h0, fwd_req, rx_pub_q, cost_ovr_q,
                      busy_tx, tx_valid, head};
  // read data register with redundancy-aware status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= pst_pkg::PST_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= pst_pkg::PST_OKAY;
      case (s_axi_araddr)
        pst_pkg::PST_REG_CTRL:   s_axi_rdata <= ctrl_q;
        pst_pkg::PST_REG_PRIO:   s_axi_rdata <= {16'h0, prio_q};
        pst_pkg::PST_REG_RATE:   s_axi_rdata <= {16'h0, rate_q};
        pst_pkg::PST_REG_COST:   s_axi_rdata <= {16'h0, cost_q};
        pst_pkg::PST_REG_NSCOST: s_axi_rdata <= {16'h0, nscost_q};
        pst_pkg::PST_REG_STAT:   s_axi_rdata <= stat;
        pst_pkg::PST_REG_CNT:    s_axi_rdata <= {n_drop_q, n_pub_q};
        pst_pkg::PST_REG_TXD:    s_axi_rdata <= {26'h0, txlen_q};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= pst_pkg::PST_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
endmodule

// File: testbench/pst_handler_chk.sv
// assertion checker bound to the frame handler top ports
module pst_handler_chk (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [7:0] rx_data,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic       tx_valid,
  input wire logic       tx_last,
  input wire logic [2:0] tx_port_mask,
  input wire logic       tx_ready,
  input wire logic [7:0] eng_data,
  input wire logic       eng_valid,
  input wire logic       eng_ready
);
  default clocking dcb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] pos_q; // byte index inside the transmit frame
  logic [7:0] hdr_b; // header byte expected at pos_q
  // count taken bytes; the closing byte restarts the index
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_q <= 8'h00;
    end else if (tx_valid && tx_ready) begin
      pos_q <= tx_last ? 8'h00 : pos_q + 8'h01;
    end
  end
  // destination byte for the first six, snap byte further on
  always_comb begin
    if (pos_q < 8'h06) begin
      hdr_b = pst_pkg::PST_MCAST[8*(5-pos_q) +: 8];
    end else begin
      hdr_b = pst_pkg::PST_SNAP[8*(21-pos_q) +: 8];
    end
  end
  a_mask_all_links: assert property (tx_port_mask == 3'h7)
    else $error("transmit not aimed at all links");
  a_tx_dest_bytes: assert property (
    tx_valid && pos_q < 8'h06 |-> tx_data == hdr_b)
    else $error("wrong destination byte");
  a_tx_snap_bytes: assert property (
    tx_valid && pos_q >= 8'h0e && pos_q <= 8'h15 |-> tx_data == hdr_b)
    else $error("wrong snap header byte");
  a_tx_stall_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
      && $stable(tx_last))
    else $error("transmit byte changed while stalled");
  a_tx_min_body: assert property (
    tx_valid && tx_last |-> pos_q >= 8'h19)
    else $error("frame closed before a whole bpdu body");
  a_eng_pass_data: assert property (
    eng_valid |-> rx_valid && eng_data == rx_data)
    else $error("engine byte not the received byte");
  a_rx_ready_link: assert property (rx_ready == eng_ready)
    else $error("receive ready not tied to engine");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
      ##0 !s_axi_arready)
    else $error("read not answered next cycle");
endmodule

bind pst_handler pst_handler_chk u_chk (.*);

// File: testbench/pst_mac_model.sv
// far-side mac model: feeds receive frames and drains transmit
module pst_mac_model #(
  parameter int SEED = 1
) (
  input  wire logic       aclk,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  output logic            rx_last,
  output logic            rx_upstream,
  input  wire logic       rx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  input  wire logic       tx_last,
  output logic            tx_ready
);
  logic [7:0] tx_q[$];   // transmit bytes as they left the block
  int         tx_frames; // frames closed by a last byte
  int         sd;        // private random state
  initial begin
    sd = SEED;
    tx_frames = 0;
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_last = 1'b0;
    rx_upstream = 1'b0;
    tx_ready = 1'b0;
  end
  // ready mostly low so the fifo backs up and must hold its head
  always @(posedge aclk) begin
    if (tx_valid && tx_ready) begin
      tx_q.push_back(tx_data);
      if (tx_last) tx_frames++;
    end
    tx_ready <= ($random(sd) & 3) == 0;
  end
  // one frame, each byte held until the block takes it
  task automatic send(input logic [7:0] f[$], input logic up);
    for (int i = 0; i < f.size(); i++) begin
      rx_data <= f[i];
      rx_valid <= 1'b1;
      rx_last <= (i == f.size() - 1);
      rx_upstream <= up;
      @(posedge aclk);
      while (rx_ready !== 1'b1) @(posedge aclk);
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~f[f.size()-1]; // idle line never shows the stale byte
  endtask
endmodule

// File: testbench/public_spanning_tree_bpdu_handler_test.sv
// self-checking bench for the public spanning tree frame handler
module public_spanning_tree_bpdu_handler_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, rx_data, tx_data, eng_data;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic        rx_valid, rx_last, rx_upstream, rx_ready, tx_valid;
  logic        tx_last, tx_ready, eng_valid, eng_last, eng_ready;
  logic [2:0]  tx_port_mask;
  logic [31:0] rd;   // last read word
  logic [7:0]  body[$]; // bpdu body under test
  logic [7:0]  fq[$];   // whole frame expected on the wire
  int          miscompares, tests_run, seed, eng_n, n;

  pst_handler #(.FIFO_DEPTH(16), .HEAD_STRAP(1'b0)) dut (.*);
  pst_mac_model #(.SEED(72897)) mac (.*);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // engine stalls at random; counts body bytes handed over
  always @(posedge aclk) begin
    eng_ready <= ($random(seed) & 3) != 0;
    if (eng_valid && eng_ready) eng_n++;
  end
  initial begin
    repeat (60000) @(posedge aclk);
    miscompares++;
    test_done();
  end

  task automatic test_done();
    if (miscompares == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one write; address and data each drop as soon as taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    bit aw, w;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1;
    w = 1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (aw && s_axi_awready) aw = 0;
      if (w && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (w && s_axi_wready) w = 0;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, pst_pkg::PST_OKAY);
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    while (s_axi_arready !== 1'b1) @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    axr(a);
    chk(rd, exp);
  endtask
  // cost rounded to nearest: 1000 / (ksym/1000 * bits)
  function automatic logic [31:0] cost_of(input int r, input int b);
    return (2000000 / (r * b) + 1) / 2;
  endfunction
  task automatic mkbody(input int cnt, input logic [7:0] ty);
    body.delete();
    repeat (cnt) body.push_back(8'($random(seed)));
    body[3] = ty;
  endtask
  // frame: destination, source, length, snap or llc, body
  task automatic build(input logic [47:0] da, input bit pub, input bit rs);
    int len;
    len = body.size() + (pub ? 8 : 3);
    fq.delete();
    for (int i = 5; i >= 0; i--) fq.push_back(da[8*i +: 8]);
    repeat (6) fq.push_back(rs ? 8'($random(seed)) : 8'h00);
    fq.push_back(8'(len >> 8));
    fq.push_back(8'(len));
    for (int i = 7; i >= (pub ? 0 : 5); i--)
      fq.push_back(pub ? pst_pkg::PST_SNAP[8*i +: 8]
                       : pst_pkg::PST_STD_LLC[8*(i-5) +: 8]);
    fq = {fq, body};
  endtask
  task automatic txsend(input int cnt, input logic [7:0] ty);
    mkbody(cnt, ty);
    axw(pst_pkg::PST_REG_TXD, 32'h00000100);
    foreach (body[j]) axw(pst_pkg::PST_REG_TXD, {24'h000000, body[j]});
    axw(pst_pkg::PST_REG_CTRL, 32'h0000000c);
    build(pst_pkg::PST_MCAST, 1'b1, 1'b0);
  endtask

  initial begin
    seed = 72897;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    eng_ready = 1'b1;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rdchk(pst_pkg::PST_REG_CTRL, 32'h00000008);
    rdchk(pst_pkg::PST_REG_PRIO, 32'h00009000);
    rdchk(pst_pkg::PST_REG_RATE, 32'h000000a0);
    rdchk(pst_pkg::PST_REG_COST, 32'h00000c35);
    rdchk(pst_pkg::PST_REG_NSCOST, 32'h0000000a);
    rdchk(pst_pkg::PST_REG_STAT, 32'h00000010);
    axr(8'h40);
    chk(rr, pst_pkg::PST_SLVERR);
    chk(rd, 32'h00000000);
    // five symbol rates, 160 to 2560 ksym/s, with both modulations
    for (int i = 0; i < 10; i++) begin
      axw(pst_pkg::PST_REG_RATE, 32'h000000a0 << (i / 2));
      axw(pst_pkg::PST_REG_CTRL, 32'h00000008 | ((i % 2) << 1));
      axr(pst_pkg::PST_REG_COST);
      chk(rd, cost_of(160 << (i / 2), (i % 2) ? 4 : 2));
    end
    // random values and the maximum 0xffff read back unchanged
    for (int i = 0; i < 4; i++) begin
      n = (i == 0) ? 32'h0000ffff : ($random(seed) & 32'h0000ffff);
      axw(pst_pkg::PST_REG_PRIO, n);
      rdchk(pst_pkg::PST_REG_PRIO, n);
      axw(pst_pkg::PST_REG_COST, n);
      rdchk(pst_pkg::PST_REG_COST, n);
    end
    // shortest body, one longer than the fifo, one random
    for (int k = 0; k < 3; k++) begin
      txsend(k == 0 ? 4 : k == 1 ? 20 : 5 + ($random(seed) & 7), 8'h00);
      for (int t = 0; t < 800 && mac.tx_frames <= k; t++) @(posedge aclk);
      chk(mac.tx_q.size(), fq.size());
      foreach (fq[j]) chk(mac.tx_q[j], fq[j]);
      mac.tx_q.delete();
    end
    // a topology change body must never leave the block
    txsend(6, pst_pkg::PST_TYPE_TCN);
    repeat (200) @(posedge aclk);
    chk(mac.tx_frames, 3);
    // public, standard, public change notice, and two half matches
    for (int k = 0; k < 5; k++) begin
      mkbody(4 + k, k == 2 ? pst_pkg::PST_TYPE_TCN : 8'h00);
      build((k == 1 || k == 4) ? pst_pkg::PST_STD_GROUP
                               : pst_pkg::PST_MCAST, k != 1 && k != 3, 1);
      eng_n = 0;
      mac.send(fq, 1'($random(seed)));
      repeat (4) @(posedge aclk);
      // a change notice shows its first three body bytes, never its end
      chk(eng_n, k == 0 ? 4 : k == 2 ? 3 : 0);
    end
    // one public frame counted, four dropped; a write clears both
    rdchk(pst_pkg::PST_REG_CNT, 32'h00040001);
    axw(pst_pkg::PST_REG_CNT, 32'h00000000);
    rdchk(pst_pkg::PST_REG_CNT, 32'h00000000);
    test_done();
  end
endmodule
